// ### hw/ecdp_pkg.sv
// package for the event counter and delayed pulse block
// assumes a single 100 MHz clock and synchronous active-high reset
`default_nettype none
package ecdp_pkg;
  // ------------------------------------------------------------
  // widths and encodings
  // ------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CAT_W = 32;
  localparam int unsigned CAT_SHIFT = 16;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [CNT_W-1:0] MIN_PHASE_CYC = 16'h0003;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic EDGE_RISE = 1'h0;
  localparam logic TB_INTERNAL = 1'h0;
  localparam logic POL_HIGH_PULSE = 1'h0;

  // gate modes
  typedef enum logic [2:0] {
    GATE_NONE = 3'h0,
    GATE_LVL_HI = 3'h1,
    GATE_LVL_LO = 3'h2,
    GATE_START_RISE = 3'h3,
    GATE_START_FALL = 3'h4,
    GATE_RETRIG_RISE = 3'h5,
    GATE_RETRIG_FALL = 3'h6
  } ecdp_gate_t;

  // pulse generator states
  typedef enum logic [1:0] {
    PG_IDLE = 2'h0,
    PG_ARMED = 2'h1,
    PG_DELAY = 2'h2,
    PG_PULSE = 2'h3
  } ecdp_pg_state_t;

  // pulse configuration carried as a group
  typedef struct packed {
    logic [CNT_W-1:0] delay_cyc;
    logic [CNT_W-1:0] width_cyc;
    logic tb_src;
    logic polarity;
    ecdp_gate_t gate_mode;
  } ecdp_pulse_cfg_t;

  // counter control group
  typedef struct packed {
    logic start;
    logic stop;
    logic src_edge;
    logic cascade;
  } ecdp_cnt_ctl_t;

  // apply the three-cycle floor to a zero request on the internal timebase
  function automatic logic [CNT_W-1:0] ecdp_phase_len(input logic [CNT_W-1:0] req,
                                                     input logic tb);
    if (req == CNT_ZERO && tb == TB_INTERNAL) begin
      return MIN_PHASE_CYC;
    end
    return req;
  endfunction : ecdp_phase_len

  // edge detect: select rising or falling transition
  function automatic logic ecdp_edge(input logic prev, input logic cur, input logic fall);
    return fall ? (prev & ~cur) : (~prev & cur);
  endfunction : ecdp_edge
endpackage : ecdp_pkg
`default_nettype wire

// ### hw/ecdp_edge_cnt.sv
// one 16-bit event counter that counts chosen edges of a synchronised input
// assumes the event input is already in the mclk_i domain
`default_nettype none
module ecdp_edge_cnt
  import ecdp_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // control
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic fall_i,
  input wire logic evt_i,
  // result
  output logic [W-1:0] cnt_o,
  output logic wrap_o
);
  // ------------------------------------------------------------
  // edge detection and count
  // ------------------------------------------------------------
  logic prev_q, prev_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic hit;

  // next values; clear has priority so a restart begins from zero
  always_comb begin
    prev_d = evt_i;
    hit = ecdp_edge(prev_q, evt_i, fall_i);
    cnt_d = cnt_q;
    if (clr_i) begin
      cnt_d = '0;
    end else if (run_i && hit) begin
      cnt_d = cnt_q + W'(1); // R1 R2
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
    end
  end

  assign cnt_o = cnt_q;
  // carry into the upper counter when cascaded
  assign wrap_o = run_i && hit && !clr_i && (cnt_q == '1);

  count_step_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R1
    (run_i && hit && !clr_i) |=> cnt_q == $past(cnt_q) + W'(1))
    else $error("counter did not step on edge");
  count_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R6
    (!run_i && !clr_i) |=> $stable(cnt_q))
    else $error("stopped counter moved");
endmodule : ecdp_edge_cnt
`default_nettype wire

// ### hw/ecdp_phase_tmr.sv
// down-counter that times one phase in timebase ticks
// assumes tick_i is in the mclk_i domain; held high it counts one tick per cycle
`default_nettype none
module ecdp_phase_tmr
  import ecdp_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] len_i,
  input wire logic tick_i,
  // status
  output logic done_o
);
  // ------------------------------------------------------------
  // remaining ticks
  // ------------------------------------------------------------
  logic [W-1:0] rem_q, rem_d;

  // load wins over counting; stops at zero
  always_comb begin
    rem_d = rem_q;
    if (load_i) begin
      rem_d = len_i;
    end else if (tick_i && rem_q != '0) begin
      rem_d = rem_q - W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rem_q <= '0;
    end else begin
      rem_q <= rem_d;
    end
  end

  // done on the tick that consumes the last cycle
  assign done_o = !load_i && tick_i && (rem_q == W'(1));
endmodule : ecdp_phase_tmr
`default_nettype wire

// ### hw/ecdp_top.sv
// event counter with cascade option plus single delayed pulse generator
// assumes external event, gate and timebase pins are already synchronised
`default_nettype none
// Behaviour
// R1: count each qualifying edge on event input
// R2: edge select 0 rising, 1 falling
// R3: cascaded count is high shifted sixteen plus low
// R4: count readable live without stopping counting
// R5: start clears, loads configuration, begins counting
// R6: stop halts selected counters
// R7: output delay level, pulse level, then back
// R8: delay phase lasts programmed timebase cycles
// R9: zero delay internal timebase becomes three cycles
// R10: pulse phase lasts programmed timebase cycles
// R11: zero width internal timebase becomes three cycles
// R12: timebase select 0 internal, 1 external
// R13: polarity 0 high pulse, 1 low pulse
// R14: gate modes zero through six supported
// R15: idle output held at delay level
// R16: external inputs synchronised before edge detect; the block has no synchroniser and takes the pins as already synchronous
module ecdp_top
  import ecdp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // event counter control
  input wire ecdp_cnt_ctl_t cnt_ctl_i,
  // pulse control
  input wire logic pulse_start_i,
  input wire logic pulse_stop_i,
  input wire ecdp_pulse_cfg_t pulse_cfg_i,
  // external pins, already synchronous
  input wire logic event_source_input_i,
  input wire logic counter_gate_input_i,
  input wire logic ext_timebase_i,
  // results
  output logic [CAT_W-1:0] count_o,
  output logic counting_o,
  output logic counter_pulse_output_o,
  output logic pulse_busy_o
);
  // ------------------------------------------------------------
  // event counting
  // ------------------------------------------------------------
  logic run_q, run_d; // counting enabled
  logic fall_q, fall_d; // latched source edge
  logic cas_q, cas_d; // latched cascade setting
  logic [CNT_W-1:0] lo_cnt, hi_cnt;
  logic lo_wrap;

  // start loads settings and runs; stop halts; start wins if both
  always_comb begin
    run_d = run_q;
    fall_d = fall_q;
    cas_d = cas_q;
    if (cnt_ctl_i.start) begin
      run_d = 1'b1; // R5
      fall_d = cnt_ctl_i.src_edge;
      cas_d = cnt_ctl_i.cascade;
    end else if (cnt_ctl_i.stop) begin
      run_d = 1'b0; // R6
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
      fall_q <= EDGE_RISE;
      cas_q <= 1'b0;
    end else begin
      run_q <= run_d;
      fall_q <= fall_d;
      cas_q <= cas_d;
    end
  end

  // lower-order counter sees events directly
  ecdp_edge_cnt #(.W(CNT_W)) u_lo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .clr_i(cnt_ctl_i.start),
    .run_i(run_q),
    .fall_i(fall_q),
    .evt_i(event_source_input_i), // R1 R16
    .cnt_o(lo_cnt),
    .wrap_o(lo_wrap)
  );

  // higher-order counter counts lower wraps when cascaded
  logic hi_evt;
  assign hi_evt = cas_q && lo_wrap;
  ecdp_edge_cnt #(.W(CNT_W)) u_hi (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .clr_i(cnt_ctl_i.start),
    .run_i(run_q),
    .fall_i(1'b0),
    .evt_i(hi_evt),
    .cnt_o(hi_cnt),
    .wrap_o()
  );

  // combine counts; the register is refreshed every cycle so reads are live
  logic [CAT_W-1:0] count_q, count_d;
  always_comb begin
    if (cas_q) begin
      count_d = (CAT_W'(hi_cnt) << CAT_SHIFT) + CAT_W'(lo_cnt); // R3
    end else begin
      count_d = CAT_W'(lo_cnt);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d; // R4
    end
  end

  assign count_o = count_q;
  assign counting_o = run_q;

  // ------------------------------------------------------------
  // timebase and gate edges
  // ------------------------------------------------------------
  logic tb_sel_q, tb_sel_d; // latched timebase source
  logic tbx_prev_q, tbx_prev_d;
  logic gate_prev_q, gate_prev_d;
  logic tick, gate_rise, gate_fall;

  // internal timebase is the system clock; external counts its rising edges
  always_comb begin
    tbx_prev_d = ext_timebase_i;
    gate_prev_d = counter_gate_input_i;
    tick = (tb_sel_q == TB_INTERNAL) ? 1'b1 :
           ecdp_edge(tbx_prev_q, ext_timebase_i, 1'b0); // R12
    gate_rise = ecdp_edge(gate_prev_q, counter_gate_input_i, 1'b0);
    gate_fall = ecdp_edge(gate_prev_q, counter_gate_input_i, 1'b1);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tbx_prev_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      tbx_prev_q <= tbx_prev_d;
      gate_prev_q <= gate_prev_d;
    end
  end

  // ------------------------------------------------------------
  // delayed pulse sequencer
  // ------------------------------------------------------------
  ecdp_pg_state_t st_q, st_d;
  logic [CNT_W-1:0] dly_q, dly_d, wid_q, wid_d;
  logic pol_q, pol_d;
  ecdp_gate_t gm_q, gm_d;
  logic out_q, out_d;
  logic ld_dly, ld_wid, dly_done, wid_done;
  logic gate_ok, trig;

  // level gating pauses timing; edge modes fire the sequence
  always_comb begin
    case (gm_q)
      GATE_LVL_HI: gate_ok = counter_gate_input_i;
      GATE_LVL_LO: gate_ok = !counter_gate_input_i;
      default: gate_ok = 1'b1;
    endcase
    case (gm_q)
      GATE_START_RISE, GATE_RETRIG_RISE: trig = gate_rise;
      GATE_START_FALL, GATE_RETRIG_FALL: trig = gate_fall;
      default: trig = 1'b0;
    endcase
  end

  // state, config capture and output level
  always_comb begin
    st_d = st_q;
    dly_d = dly_q;
    wid_d = wid_q;
    pol_d = pol_q;
    gm_d = gm_q;
    tb_sel_d = tb_sel_q;
    ld_dly = 1'b0;
    ld_wid = 1'b0;
    if (pulse_start_i) begin
      // capture config; floor zero requests on internal timebase
      dly_d = ecdp_phase_len(pulse_cfg_i.delay_cyc, pulse_cfg_i.tb_src); // R9
      wid_d = ecdp_phase_len(pulse_cfg_i.width_cyc, pulse_cfg_i.tb_src); // R11
      pol_d = pulse_cfg_i.polarity; // R13
      gm_d = pulse_cfg_i.gate_mode;
      tb_sel_d = pulse_cfg_i.tb_src; // R12
      case (pulse_cfg_i.gate_mode)
        GATE_NONE, GATE_LVL_HI, GATE_LVL_LO: begin
          st_d = PG_DELAY;
          ld_dly = 1'b1;
        end
        default: st_d = PG_ARMED; // R14
      endcase
    end else if (pulse_stop_i) begin
      st_d = PG_IDLE; // R6
    end else begin
      case (st_q)
        PG_IDLE: st_d = PG_IDLE; // R15
        PG_ARMED: begin
          if (trig) begin
            st_d = PG_DELAY; // R14
            ld_dly = 1'b1;
          end
        end
        PG_DELAY: begin
          if (dly_done) begin
            st_d = PG_PULSE; // R8
            ld_wid = 1'b1;
          end
        end
        PG_PULSE: begin
          if ((gm_q == GATE_RETRIG_RISE || gm_q == GATE_RETRIG_FALL) && trig) begin
            st_d = PG_DELAY; // R14
            ld_dly = 1'b1;
          end else if (wid_done) begin
            // one-shot modes return to idle; retrigger modes wait again
            st_d = (gm_q == GATE_RETRIG_RISE || gm_q == GATE_RETRIG_FALL) ?
                   PG_ARMED : PG_IDLE; // R10
          end
        end
        default: st_d = PG_IDLE;
      endcase
    end
    // pulse level only in the pulse phase, else the delay level
    out_d = (st_d == PG_PULSE) ? ~pol_d : pol_d; // R7 R13 R15
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q <= PG_IDLE;
      dly_q <= MIN_PHASE_CYC;
      wid_q <= MIN_PHASE_CYC;
      pol_q <= POL_HIGH_PULSE;
      gm_q <= GATE_NONE;
      tb_sel_q <= TB_INTERNAL;
      out_q <= POL_HIGH_PULSE;
    end else begin
      st_q <= st_d;
      dly_q <= dly_d;
      wid_q <= wid_d;
      pol_q <= pol_d;
      gm_q <= gm_d;
      tb_sel_q <= tb_sel_d;
      out_q <= out_d;
    end
  end

  // phase timers; ticks only count while the level gate allows
  ecdp_phase_tmr #(.W(CNT_W)) u_dly (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .load_i(ld_dly),
    .len_i(dly_d),
    .tick_i(tick && gate_ok && st_q == PG_DELAY), // R8
    .done_o(dly_done)
  );
  ecdp_phase_tmr #(.W(CNT_W)) u_wid (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .load_i(ld_wid),
    .len_i(wid_q),
    .tick_i(tick && gate_ok && st_q == PG_PULSE), // R10
    .done_o(wid_done)
  );

  assign counter_pulse_output_o = out_q;
  assign pulse_busy_o = (st_q == PG_DELAY) || (st_q == PG_PULSE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  idle_level_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R15
    (st_q == PG_IDLE || st_q == PG_ARMED) |-> out_q == pol_q)
    else $error("idle output not at delay level");
  pulse_level_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R13
    (st_q == PG_PULSE) |-> out_q == ~pol_q)
    else $error("pulse phase level wrong");
  min_delay_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R9
    (pulse_start_i && pulse_cfg_i.delay_cyc == CNT_ZERO && !pulse_cfg_i.tb_src)
    |=> dly_q == MIN_PHASE_CYC)
    else $error("zero delay not floored to three");
  min_width_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R11
    (pulse_start_i && pulse_cfg_i.width_cyc == CNT_ZERO && !pulse_cfg_i.tb_src)
    |=> wid_q == MIN_PHASE_CYC)
    else $error("zero width not floored to three");
  // three delay cycles follow the start edge, so the pulse shows on the fourth edge
  delay_len_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R8
    (pulse_start_i && pulse_cfg_i.gate_mode == GATE_NONE && !pulse_cfg_i.tb_src
     && pulse_cfg_i.delay_cyc == CNT_ZERO) ##1 (!pulse_stop_i && !pulse_start_i)[*3]
    |=> st_q == PG_PULSE)
    else $error("delay phase length wrong");
  phase_order_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R7
    (st_q == PG_PULSE && st_d == PG_IDLE && !pulse_stop_i && !pulse_start_i)
    |-> $past(wid_done) == 1'b0 ##0 wid_done)
    else $error("pulse ended without width expiry");
  cascade_sum_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R3
    cas_q && $stable(cas_q) |=> count_q == (CAT_W'($past(hi_cnt)) << CAT_SHIFT)
    + CAT_W'($past(lo_cnt)))
    else $error("cascaded count wrong");
  live_read_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R4
    !cas_q && $stable(cas_q) |=> count_q == CAT_W'($past(lo_cnt)))
    else $error("count not live");
  start_run_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R5
    cnt_ctl_i.start |=> run_q && lo_cnt == CNT_ZERO)
    else $error("start did not clear and run");
  stop_halt_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R6
    (cnt_ctl_i.stop && !cnt_ctl_i.start) |=> !run_q)
    else $error("stop did not halt");
  armed_wait_a: assert property (@(posedge mclk_i) disable iff (srst_i) // R14
    (st_q == PG_ARMED && !trig && !pulse_start_i && !pulse_stop_i) |=> st_q == PG_ARMED)
    else $error("armed state left without gate edge");

  pulse_seen_c: cover property (@(posedge mclk_i) disable iff (srst_i)
    st_q == PG_DELAY ##1 st_q == PG_PULSE);
  retrig_c: cover property (@(posedge mclk_i) disable iff (srst_i)
    st_q == PG_PULSE && gm_q == GATE_RETRIG_RISE ##1 st_q == PG_DELAY);
  cascade_c: cover property (@(posedge mclk_i) disable iff (srst_i)
    cas_q && lo_wrap);
endmodule : ecdp_top
`default_nettype wire

// ### dv/ecdp_partner.sv
// partner model: event source, gate driver, external timebase and pulse consumer
// assumes every pin it drives changes just after a rising edge of mclk_i
`default_nettype none
module ecdp_partner #(
  parameter int TB_HALF = 2
) (
  // clock
  input wire logic mclk_i,
  // consumer control
  input wire logic clr_i,
  input wire logic pol_i,
  input wire logic tb_run_i,
  input wire logic pulse_i,
  // pins toward the block
  output var logic evt_o,
  output var logic gate_o,
  output var logic tb_o,
  // consumer tallies
  output var int pulse_cyc_o,
  output var int pulse_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  int ph_q; // half-period count of the timebase
  logic prev_q; // pulse level seen last cycle
  initial begin
    evt_o = 1'b0;
    gate_o = 1'b0;
    tb_o = 1'b0;
    ph_q = 0;
    prev_q = 1'b0;
  end
  // timebase only toggles while enabled so idle tests see no stray ticks
  always @(posedge mclk_i) begin
    if (!tb_run_i) begin
      ph_q <= 0;
      tb_o <= 1'b0;
    end else if (ph_q == TB_HALF - 1) begin
      ph_q <= 0;
      tb_o <= ~tb_o;
    end else begin
      ph_q <= ph_q + 1;
    end
  end
  // --------------------------------------------------------------
  // consumer: cycles at pulse level and entries into it
  // --------------------------------------------------------------
  always @(posedge mclk_i) begin
    prev_q <= pulse_i ^ pol_i;
    if (clr_i) begin
      pulse_cyc_o <= 0;
      pulse_n_o <= 0;
    end else begin
      // an unknown output counts as a pulse cycle, so it cannot hide
      if (pulse_i !== pol_i) begin
        pulse_cyc_o <= pulse_cyc_o + 1;
      end
      if ((pulse_i ^ pol_i) === 1'b1 && prev_q === 1'b0) begin
        pulse_n_o <= pulse_n_o + 1;
      end
    end
  end
  // edge-synchronous pin changes keep inputs inside the clock domain
  task automatic set_evt(input logic v);
    @(posedge mclk_i);
    evt_o <= v;
  endtask : set_evt
  task automatic set_gate(input logic v);
    @(posedge mclk_i);
    gate_o <= v;
  endtask : set_gate
  task automatic emit(input int n);
    repeat (n) begin
      set_evt(1'b1);
      set_evt(1'b0);
    end
  endtask : emit
endmodule : ecdp_partner
`default_nettype wire

// ### dv/ecdp_top_tb.sv
// testbench for the event counter and delayed pulse block
// assumes the partner model drives the external pins in the mclk_i domain
`default_nettype none
module ecdp_top_tb
  import ecdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic mclk, srst, pstart, pstop, clr, pol, tb_run;
  ecdp_cnt_ctl_t cnt_ctl;
  ecdp_pulse_cfg_t cfg;
  logic [CAT_W-1:0] count;
  logic counting, pout, busy;
  logic evt, gate, tbx;
  int pcyc, pn, busy_cyc, mismatches, check_count;
  ecdp_top ecdp_top_i (.mclk_i(mclk), .srst_i(srst), .cnt_ctl_i(cnt_ctl),
    .pulse_start_i(pstart), .pulse_stop_i(pstop), .pulse_cfg_i(cfg),
    .event_source_input_i(evt), .counter_gate_input_i(gate), .ext_timebase_i(tbx),
    .count_o(count), .counting_o(counting), .counter_pulse_output_o(pout),
    .pulse_busy_o(busy));
  ecdp_partner ecdp_partner_i (.mclk_i(mclk), .clr_i(clr), .pol_i(pol),
    .tb_run_i(tb_run), .pulse_i(pout), .evt_o(evt), .gate_o(gate), .tb_o(tbx),
    .pulse_cyc_o(pcyc), .pulse_n_o(pn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // busy length of the pulse launched last
  always @(posedge mclk) begin
    if (pstart) begin
      busy_cyc <= 0;
    end else if (busy === 1'b1) begin
      busy_cyc <= busy_cyc + 1;
    end
  end
  // --------------------------------------------------------------
  // compare and helper tasks
  // --------------------------------------------------------------
  task automatic chk_cnt(input string nm, input logic [CAT_W-1:0] e, input logic [CAT_W-1:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_cnt
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_num(input string nm, input int e, input int g);
    check_count++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_num
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // waits n edges, then lets that edge's updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic cnt_cmd(input logic go, input logic fall, input logic casc);
    @(posedge mclk);
    cnt_ctl <= '{start: go, stop: ~go, src_edge: fall, cascade: casc};
    @(posedge mclk);
    cnt_ctl.start <= 1'b0;
    cnt_ctl.stop <= 1'b0;
  endtask : cnt_cmd
  // consumer clear is held two edges so a polarity swap is not tallied
  task automatic pulse_go(input logic [15:0] d, input logic [15:0] w, input logic tb,
                          input logic p, input ecdp_gate_t gm);
    @(posedge mclk);
    cfg <= '{d, w, tb, p, gm};
    pstart <= 1'b1;
    clr <= 1'b1;
    pol <= p;
    @(posedge mclk);
    pstart <= 1'b0;
    @(posedge mclk);
    clr <= 1'b0;
  endtask : pulse_go
  task automatic p_stop();
    @(posedge mclk);
    pstop <= 1'b1;
    @(posedge mclk);
    pstop <= 1'b0;
  endtask : p_stop
  task automatic wait_idle(input int bound);
    int i;
    i = 0;
    cyc(3);
    while (busy !== 1'b0 && i < bound) begin
      cyc(1);
      i++;
    end
    cyc(2);
    if (i >= bound) chk_bit("busy_timeout", 1'b0, busy);
  endtask : wait_idle
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_edge(input logic fall);
    cnt_cmd(1'b1, fall, 1'b0);
    cyc(2);
    chk_bit("counting", 1'b1, counting);
    chk_cnt("count_clear", 32'h0000_0000, count);
    ecdp_partner_i.set_evt(1'b1);
    cyc(3);
    chk_cnt("count_rise", {31'h0, ~fall}, count);
    ecdp_partner_i.set_evt(1'b0);
    cyc(3);
    chk_cnt("count_fall", 32'h0000_0001, count);
    ecdp_partner_i.emit(5);
    cyc(3);
    chk_cnt("count_live", 32'h0000_0006, count);
  endtask : t_edge
  task automatic t_stop();
    cnt_cmd(1'b0, 1'b0, 1'b0);
    cyc(2);
    chk_bit("counting_stop", 1'b0, counting);
    ecdp_partner_i.emit(3);
    cyc(3);
    chk_cnt("count_held", 32'h0000_0006, count);
    cnt_cmd(1'b1, 1'b0, 1'b1);
    ecdp_partner_i.emit(4);
    cyc(3);
    chk_cnt("count_cascade", 32'h0000_0004, count);
  endtask : t_stop
  task automatic t_pulse(input logic [15:0] d, input logic [15:0] w, input logic p,
                         input int ed, input int ew);
    pulse_go(d, w, TB_INTERNAL, p, GATE_NONE);
    wait_idle(300);
    chk_num("pulse_cycles", ew, pcyc);
    chk_num("pulse_count", 1, pn);
    chk_num("busy_cycles", ed + ew, busy_cyc);
    chk_bit("idle_level", p, pout);
  endtask : t_pulse
  // timebase of four clocks; its first rise lands in the first delay cycle
  task automatic t_ext();
    @(posedge mclk);
    tb_run <= 1'b1;
    pulse_go(16'h0002, 16'h0003, 1'b1, 1'b0, GATE_NONE);
    wait_idle(300);
    chk_num("ext_pulse_cycles", 12, pcyc);
    chk_num("ext_pulse_count", 1, pn);
    chk_num("ext_busy_cycles", 17, busy_cyc);
    @(posedge mclk);
    tb_run <= 1'b0;
  endtask : t_ext
  // level modes hold the gate active; edge modes see two edges of their kind
  task automatic t_gate(input ecdp_gate_t gm);
    logic g0;
    g0 = (gm == GATE_LVL_HI || gm == GATE_START_FALL || gm == GATE_RETRIG_FALL);
    ecdp_partner_i.set_gate(g0);
    pulse_go(16'h0003, 16'h0002, TB_INTERNAL, 1'b0, gm);
    if (gm >= GATE_START_RISE) begin
      cyc(8);
      chk_num("armed_quiet", 0, pn);
      ecdp_partner_i.set_gate(~g0);
      wait_idle(100);
      ecdp_partner_i.set_gate(g0);
      ecdp_partner_i.set_gate(~g0);
    end
    wait_idle(100);
    chk_num("gate_pulses", (gm >= GATE_RETRIG_RISE) ? 2 : 1, pn);
    chk_num("gate_cycles", (gm >= GATE_RETRIG_RISE) ? 4 : 2, pcyc);
    p_stop();
  endtask : t_gate
  task automatic t_abort();
    pulse_go(16'h0028, 16'h0004, TB_INTERNAL, 1'b0, GATE_NONE);
    cyc(5);
    p_stop();
    cyc(50);
    chk_bit("abort_busy", 1'b0, busy);
    chk_num("abort_pulses", 0, pn);
  endtask : t_abort
  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    srst = 1'b1;
    cnt_ctl = '0;
    pstart = 1'b0;
    pstop = 1'b0;
    cfg = '0;
    clr = 1'b1;
    pol = 1'b0;
    tb_run = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    clr <= 1'b0;
    cyc(1);
    chk_cnt("reset_count", 32'h0000_0000, count);
    chk_bit("reset_out", 1'b0, pout);
    t_edge(1'b0);
    t_edge(1'b1);
    t_stop();
    t_pulse(16'h0005, 16'h0004, 1'b0, 5, 4);
    t_pulse(16'h0000, 16'h0000, 1'b0, 3, 3);
    t_pulse(16'h0007, 16'h0000, 1'b1, 7, 3);
    t_ext();
    for (int m = 0; m < 7; m++) t_gate(ecdp_gate_t'(m));
    t_abort();
    report_and_stop();
  end
  // far beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : ecdp_top_tb
`default_nettype wire
